// file: verilog/scc_calendar_cfg.sv
/*
 * Status-channel calendar configuration: register slave plus slot sequencer.
 * Assumes a bus master that holds each request until waitrequest is low,
 * and a calendar-select pin from the status-channel decoder on the transmit side.
 */
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module scc_calendar_cfg #(
    parameter bit TX_SIDE = 1'b0
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_arst_n,
    input  wire logic [scc_pkg::ADDR_W-1:0]  i_address,
    input  wire logic                        i_read,
    input  wire logic                        i_write,
    input  wire logic [31:0]                 i_writedata,
    input  wire logic [3:0]                  i_byteenable,
    output logic      [31:0]                 o_readdata,
    output logic                             o_waitrequest,
    input  wire logic                        i_link_cal_sel,
    output logic                             o_stat_valid,
    output logic      [scc_pkg::PORT_W-1:0]  o_stat_port,
    output logic                             o_stat_frame_start,
    output logic                             o_stat_cal
);
    logic                        ack_q;
    logic                        status_frame_disable_q;
    logic                        active_calendar_request_q;
    logic [scc_pkg::LEN_W-1:0]   calendar_zero_length_q;
    logic [scc_pkg::MULT_W-1:0]  calendar_zero_multiplier_q;
    logic [scc_pkg::LEN_W-1:0]   calendar_one_length_q;
    logic [scc_pkg::MULT_W-1:0]  calendar_one_multiplier_q;
    logic [scc_pkg::SLOT_W-1:0]  slot_index_reg_q;
    logic                        wr_stb;
    logic                        we0;
    logic                        we1;
    logic [scc_pkg::PORT_W-1:0]  seq_data0;
    logic [scc_pkg::PORT_W-1:0]  seq_data1;
    logic [scc_pkg::PORT_W-1:0]  bus_data0;
    logic [scc_pkg::PORT_W-1:0]  bus_data1;
    logic                        link_sel;
    logic                        sel_src;
    logic                        cal_q;
    logic [scc_pkg::LEN_W-1:0]   slot_q;
    logic [scc_pkg::MULT_W-1:0]  rep_q;
    logic                        run;
    logic [scc_pkg::LEN_W-1:0]   len_raw;
    logic [scc_pkg::LEN_W-1:0]   len_eff;
    logic [scc_pkg::MULT_W-1:0]  mult_eff;
    logic                        last_slot;
    logic                        last_rep;
    logic                        pend_valid_q;
    logic                        pend_first_q;
    logic                        pend_cal_q;
    logic [31:0]                 rd_d;
    logic                        rd_stb;
    logic                        wr_ctrl;
    logic                        wr_calendar_zero;
    logic                        wr_calendar_one;
    logic                        wr_idx;
    logic                        frame_end;

    // Each access answers on the second cycle of its request; writes land there
    assign o_waitrequest = (i_read | i_write) & ~ack_q;
    assign wr_stb        = i_write & ack_q;
    assign rd_stb        = i_read & ~ack_q;
    assign wr_ctrl       = wr_stb & (i_address == scc_pkg::OFS_CTRL);
    assign wr_calendar_zero       = wr_stb & (i_address == scc_pkg::OFS_CALENDAR_ZERO_CFG);
    assign wr_calendar_one       = wr_stb & (i_address == scc_pkg::OFS_CALENDAR_ONE_CFG);
    assign wr_idx        = wr_stb & (i_address == scc_pkg::OFS_SLOT_IDX);
    assign we0           = wr_stb & (i_address == scc_pkg::OFS_DAT0) & i_byteenable[0];
    assign we1           = wr_stb & (i_address == scc_pkg::OFS_DAT1) & i_byteenable[0];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_read | i_write) & ~ack_q;
        end
    end

    // Control register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_frame_disable_q    <= scc_pkg::RST_DISABLE;
            active_calendar_request_q <= 1'b0;
        end else if (wr_ctrl && i_byteenable[0]) begin
            status_frame_disable_q    <= i_writedata[scc_pkg::CTRL_DIS_BIT];
            active_calendar_request_q <= i_writedata[scc_pkg::CTRL_SEL_BIT];
        end
    end

    // Calendar 0 length and multiplier
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            calendar_zero_length_q     <= scc_pkg::RST_LEN;
            calendar_zero_multiplier_q <= scc_pkg::RST_MULT;
        end else if (wr_calendar_zero) begin
            if (i_byteenable[0]) begin
                calendar_zero_length_q[7:0] <= i_writedata[7:0];
            end
            if (i_byteenable[1]) begin
                calendar_zero_length_q[10:8] <= i_writedata[10:8];
            end
            if (i_byteenable[2]) begin
                calendar_zero_multiplier_q <= i_writedata[scc_pkg::CFG_MULT_LSB +: scc_pkg::MULT_W];
            end
        end
    end

    // Calendar 1 length and multiplier
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            calendar_one_length_q     <= scc_pkg::RST_LEN;
            calendar_one_multiplier_q <= scc_pkg::RST_MULT;
        end else if (wr_calendar_one) begin
            if (i_byteenable[0]) begin
                calendar_one_length_q[7:0] <= i_writedata[7:0];
            end
            if (i_byteenable[1]) begin
                calendar_one_length_q[10:8] <= i_writedata[10:8];
            end
            if (i_byteenable[2]) begin
                calendar_one_multiplier_q <= i_writedata[scc_pkg::CFG_MULT_LSB +: scc_pkg::MULT_W];
            end
        end
    end

    // Shared slot index for indirect table access
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slot_index_reg_q <= '0;
        end else if (wr_idx) begin
            if (i_byteenable[0]) begin
                slot_index_reg_q[7:0] <= i_writedata[7:0];
            end
            if (i_byteenable[1]) begin
                slot_index_reg_q[9:8] <= i_writedata[9:8];
            end
        end
    end

    // Two independent tables
    scc_cal_table u_cal_zero (
        .i_clk      (i_clk),
        .i_we       (we0),
        .i_waddr    (slot_index_reg_q),
        .i_wdata    (i_writedata[scc_pkg::PORT_W-1:0]),
        .i_seq_addr (slot_q[scc_pkg::SLOT_W-1:0]),
        .o_seq_data (seq_data0),
        .i_bus_addr (slot_index_reg_q),
        .o_bus_data (bus_data0)
    );

    scc_cal_table u_cal_one (
        .i_clk      (i_clk),
        .i_we       (we1),
        .i_waddr    (slot_index_reg_q),
        .i_wdata    (i_writedata[scc_pkg::PORT_W-1:0]),
        .i_seq_addr (slot_q[scc_pkg::SLOT_W-1:0]),
        .o_seq_data (seq_data1),
        .i_bus_addr (slot_index_reg_q),
        .o_bus_data (bus_data1)
    );

    scc_sync3 u_link_sel_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_async  (i_link_cal_sel),
        .o_level  (link_sel)
    );

    // Calendar choice: register on receive, link word on transmit
    assign sel_src = TX_SIDE ? link_sel : active_calendar_request_q;

    // Effective length and multiplier of the calendar in use
    always_comb begin
        if (cal_q) begin
            len_raw  = calendar_one_length_q;
            mult_eff = calendar_one_multiplier_q;
        end else begin
            len_raw  = calendar_zero_length_q;
            mult_eff = calendar_zero_multiplier_q;
        end
        if (len_raw > scc_pkg::LEN_MAX) begin
            len_eff = scc_pkg::LEN_MAX;
        end else begin
            len_eff = len_raw;
        end
    end
    assign run       = ~status_frame_disable_q & (len_eff != '0);
    assign last_slot = (slot_q == len_eff - 11'h001);
    assign last_rep  = (rep_q + 8'h01 >= mult_eff);
    assign frame_end = last_slot & last_rep;

    // Slot counter
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slot_q <= '0;
        end else if (!run || last_slot) begin
            slot_q <= '0;
        end else begin
            slot_q <= slot_q + 11'h001;
        end
    end

    // Repeat counter
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rep_q <= '0;
        end else if (!run) begin
            rep_q <= '0;
        end else if (last_slot) begin
            if (last_rep) begin
                rep_q <= '0;
            end else begin
                rep_q <= rep_q + 8'h01;
            end
        end
    end

    // Calendar choice taken only while stopped or at a frame boundary
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cal_q <= 1'b0;
        end else if (!run || frame_end) begin
            cal_q <= sel_src;
        end
    end

    // Table read takes a cycle; align valid and frame marker with data
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_valid_q <= 1'b0;
            pend_first_q <= 1'b0;
            pend_cal_q   <= 1'b0;
        end else begin
            pend_valid_q <= run;
            pend_first_q <= run & (slot_q == '0) & (rep_q == '0);
            pend_cal_q   <= cal_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_stat_valid       <= 1'b0;
            o_stat_frame_start <= 1'b0;
        end else begin
            o_stat_valid       <= pend_valid_q & ~status_frame_disable_q;
            o_stat_frame_start <= pend_first_q & ~status_frame_disable_q;
        end
    end

    // Port and calendar of the presented slot
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_stat_port <= '0;
            o_stat_cal  <= 1'b0;
        end else begin
            o_stat_port <= pend_cal_q ? seq_data1 : seq_data0;
            o_stat_cal  <= pend_cal_q;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        case (i_address)
            scc_pkg::OFS_CTRL: begin
                rd_d[scc_pkg::CTRL_DIS_BIT] = status_frame_disable_q;
                rd_d[scc_pkg::CTRL_SEL_BIT] = active_calendar_request_q;
            end
            scc_pkg::OFS_CALENDAR_ZERO_CFG: begin
                rd_d[scc_pkg::CFG_LEN_LSB +: scc_pkg::LEN_W]   = calendar_zero_length_q;
                rd_d[scc_pkg::CFG_MULT_LSB +: scc_pkg::MULT_W] = calendar_zero_multiplier_q;
            end
            scc_pkg::OFS_CALENDAR_ONE_CFG: begin
                rd_d[scc_pkg::CFG_LEN_LSB +: scc_pkg::LEN_W]   = calendar_one_length_q;
                rd_d[scc_pkg::CFG_MULT_LSB +: scc_pkg::MULT_W] = calendar_one_multiplier_q;
            end
            scc_pkg::OFS_SLOT_IDX: begin
                rd_d[scc_pkg::SLOT_W-1:0] = slot_index_reg_q;
            end
            scc_pkg::OFS_DAT0: begin
                rd_d[scc_pkg::PORT_W-1:0] = bus_data0;
            end
            scc_pkg::OFS_DAT1: begin
                rd_d[scc_pkg::PORT_W-1:0] = bus_data1;
            end
            scc_pkg::OFS_STATUS: begin
                rd_d[scc_pkg::STS_RUN_BIT] = run;
                rd_d[scc_pkg::STS_CAL_BIT] = cal_q;
                rd_d[scc_pkg::STS_SLOT_LSB +: scc_pkg::LEN_W] = slot_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // Read data registered at the waiting cycle, stands at the answer edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_readdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            o_readdata <= rd_d;
        end
    end
endmodule : scc_calendar_cfg

// file: verilog/scc_pkg.sv
/*
 * Shared constants for the status-channel calendar configuration block.
 * Assumes a single 20 MHz core clock and a 32-bit register bus.
 */
// What this block does
// - A calendar holds up to 1,024 slots, each naming a port, with the maximum set at build time.
// - With hitless reprovisioning built in there are two calendars, each with its own slot table.
// - Writing a port number to data register zero stores it at the indexed slot of calendar 0.
// - Writing a port number to data register one stores it at the indexed slot of calendar 1.
// - Writing 1 to the status-frame disable bit stops the status channel.
// - Writing 0 to the status-frame disable bit restarts status generation.
// - Calendar 0 has a writable multiplier and a writable length that sets its slot count.
// - Calendar 1 has its own writable multiplier and length, apart from calendar 0.
// - On the receive side software picks the active calendar through a request field.
// - On the transmit side the calendar-select word from the status channel picks the calendar.
// - Both ends of the link hold identical slot-to-port tables.
// - One port may occupy several slots to gain status bandwidth.
package scc_pkg;
    localparam int          CAL_DEPTH    = 1024;
    localparam int          SLOT_W       = 10;
    localparam int          LEN_W        = 11;
    localparam int          MULT_W       = 8;
    localparam int          PORT_W       = 8;
    localparam int          ADDR_W       = 5;

    localparam logic [4:0]  OFS_CTRL     = 5'h00;
    localparam logic [4:0]  OFS_CALENDAR_ZERO_CFG = 5'h04;
    localparam logic [4:0]  OFS_CALENDAR_ONE_CFG = 5'h08;
    localparam logic [4:0]  OFS_SLOT_IDX = 5'h0C;
    localparam logic [4:0]  OFS_DAT0     = 5'h10;
    localparam logic [4:0]  OFS_DAT1     = 5'h14;
    localparam logic [4:0]  OFS_STATUS   = 5'h18;

    localparam int          CTRL_DIS_BIT = 0;
    localparam int          CTRL_SEL_BIT = 1;
    localparam int          CFG_LEN_LSB  = 0;
    localparam int          CFG_MULT_LSB = 16;
    localparam int          STS_RUN_BIT  = 0;
    localparam int          STS_CAL_BIT  = 1;
    localparam int          STS_SLOT_LSB = 16;

    localparam logic              RST_DISABLE = 1'b1;
    localparam logic [LEN_W-1:0]  RST_LEN     = 11'h000;
    localparam logic [MULT_W-1:0] RST_MULT    = 8'h01;
    localparam logic [LEN_W-1:0]  LEN_MAX     = 11'h400;
    localparam int                SYNC_STAGES = 3;
endpackage : scc_pkg

// file: verilog/scc_sync3.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to i_clk.
 */
`timescale 1ns/1ps
module scc_sync3 (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_level <= 1'b0;
        end else if (s2_q == s3_q) begin
            o_level <= s3_q;
        end
    end
endmodule : scc_sync3

// file: verilog/scc_cal_table.sv
/*
 * One calendar slot-to-port table: one write port, two registered read ports.
 * Assumes contents are undefined until software writes them.
 */
`timescale 1ns/1ps
module scc_cal_table (
    input  wire logic                        i_clk,
    input  wire logic                        i_we,
    input  wire logic [scc_pkg::SLOT_W-1:0]  i_waddr,
    input  wire logic [scc_pkg::PORT_W-1:0]  i_wdata,
    input  wire logic [scc_pkg::SLOT_W-1:0]  i_seq_addr,
    output logic      [scc_pkg::PORT_W-1:0]  o_seq_data,
    input  wire logic [scc_pkg::SLOT_W-1:0]  i_bus_addr,
    output logic      [scc_pkg::PORT_W-1:0]  o_bus_data
);
    logic [scc_pkg::PORT_W-1:0] mem [scc_pkg::CAL_DEPTH];

    // No reset on the array; software must fill it
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_seq_data <= mem[i_seq_addr];
        o_bus_data <= mem[i_bus_addr];
    end
endmodule : scc_cal_table

// file: tb/scc_calendar_cfg_props.sv
/* Bus and status-stream checks for scc_calendar_cfg.
   Sees only the top ports; bound in below. */
`timescale 1ns/1ps
module scc_calendar_cfg_props (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic [4:0]  i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0]  i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic        i_link_cal_sel,
    input wire logic        o_stat_valid,
    input wire logic [7:0]  o_stat_port,
    input wire logic        o_stat_frame_start,
    input wire logic        o_stat_cal
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic bus_req;
    assign bus_req = i_read | i_write;
    a_wait_first: assert property ($rose(bus_req) |-> o_waitrequest)
        else $error("no wait cycle on new request");
    a_wait_one: assert property (bus_req && o_waitrequest ##1 bus_req |-> !o_waitrequest)
        else $error("more than one wait cycle");
    a_idle_nowait: assert property (!bus_req |-> !o_waitrequest)
        else $error("waitrequest high while idle");
    a_frame_valid: assert property (o_stat_frame_start |-> o_stat_valid)
        else $error("frame start without valid slot");
    a_run_start: assert property ($rose(o_stat_valid) |-> o_stat_frame_start)
        else $error("run does not begin with frame start");
    a_cal_hold: assert property (o_stat_valid && !o_stat_frame_start |-> $stable(o_stat_cal))
        else $error("calendar changed inside a frame");
    a_stop_valid: assert property (i_write && !o_waitrequest && i_address == scc_pkg::OFS_CTRL
        && i_byteenable[0] && i_writedata[0] |-> ##2 !o_stat_valid [*3])
        else $error("status still valid after disable");
    a_unmapped_zero: assert property (i_read && !o_waitrequest && i_address == 5'h1C
        |-> o_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : scc_calendar_cfg_props

bind scc_calendar_cfg scc_calendar_cfg_props u_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_link_cal_sel(i_link_cal_sel), .o_stat_valid(o_stat_valid), .o_stat_port(o_stat_port),
    .o_stat_frame_start(o_stat_frame_start), .o_stat_cal(o_stat_cal));

// file: tb/scc_calendar_cfg_tb.sv
/* Self-checking bench for scc_calendar_cfg, receive and transmit ends.
   Assumes the bound checker and a 20 MHz clock. */
`timescale 1ns/1ps
module scc_calendar_cfg_tb;
    logic        i_clk, i_arst_n, i_read, i_write, i_link_cal_sel;
    logic [4:0]  i_address;
    logic [31:0] i_writedata, o_readdata, rd;
    logic [3:0]  i_byteenable;
    logic        o_waitrequest, o_stat_valid, o_stat_frame_start, o_stat_cal;
    logic [7:0]  o_stat_port;
    logic        tx_valid, tx_start, tx_cal;
    logic [7:0]  tx_port;
    logic [7:0]  e0 [6] = '{8'h00, 8'h03, 8'h02, 8'h03, 8'h01, 8'h00};
    logic [7:0]  e1 [6] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h02, 8'h03};
    int          bad_count, cmp_count;
    scc_calendar_cfg #(.TX_SIDE(1'b0)) u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_link_cal_sel(i_link_cal_sel),
        .o_stat_valid(o_stat_valid), .o_stat_port(o_stat_port),
        .o_stat_frame_start(o_stat_frame_start), .o_stat_cal(o_stat_cal));
    scc_calendar_cfg #(.TX_SIDE(1'b1)) u_dut_tx (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(),
        .o_waitrequest(), .i_link_cal_sel(i_link_cal_sel),
        .o_stat_valid(tx_valid), .o_stat_port(tx_port),
        .o_stat_frame_start(tx_start), .o_stat_cal(tx_cal));
    always #25 i_clk = ~i_clk;
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            $display("mismatch %s expected %h seen %h", nm, ex, got);
            bad_count++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= ~wr;
        @(posedge i_clk);
        while (o_waitrequest !== 1'b0 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        rd = o_readdata;
        if (n >= 20) begin
            $display("mismatch waitrequest expected 0 seen 1");
            bad_count++;
        end
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk);
    endtask : bus
    task automatic run_frame(input logic cal, input logic [7:0] e [6], input int n);
        int k;
        k = 0;
        while (!(o_stat_frame_start === 1'b1 && o_stat_cal === cal) && k < 200) begin
            @(posedge i_clk);
            k++;
        end
        chk("frame start", 32'h1, 32'(o_stat_frame_start));
        for (int i = 0; i < n; i++) begin
            chk("valid", 32'h1, 32'(o_stat_valid));
            chk("port", 32'(e[i]), 32'(o_stat_port));
            chk("cal", 32'(cal), 32'(o_stat_cal));
            if (i > 0) chk("mid start", 32'h0, 32'(o_stat_frame_start));
            @(posedge i_clk);
        end
        chk("next frame", 32'h1, 32'(o_stat_frame_start));
    endtask : run_frame
    task automatic t_reset();
        bus(1'b0, scc_pkg::OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0000_0001, rd);
        bus(1'b0, scc_pkg::OFS_CALENDAR_ZERO_CFG, 32'h0);
        chk("calendar_zero reset", 32'h0001_0000, rd);
        bus(1'b0, 5'h1C, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset
    task automatic t_program();
        bus(1'b1, scc_pkg::OFS_CALENDAR_ZERO_CFG, 32'h0001_0005);
        bus(1'b1, scc_pkg::OFS_CALENDAR_ONE_CFG, 32'h0002_0003);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, scc_pkg::OFS_SLOT_IDX, i);
            bus(1'b1, scc_pkg::OFS_DAT0, {24'h0, e0[i]});
            if (i < 3) bus(1'b1, scc_pkg::OFS_DAT1, {24'h0, e1[i]});
        end
        bus(1'b1, scc_pkg::OFS_SLOT_IDX, 32'h1);
        i_byteenable <= 4'hE;
        bus(1'b1, scc_pkg::OFS_DAT0, 32'h7);
        i_byteenable <= 4'hF;
        bus(1'b0, scc_pkg::OFS_DAT0, 32'h0);
        chk("calendar_zero slot1", 32'h3, rd);
        bus(1'b0, scc_pkg::OFS_DAT1, 32'h0);
        chk("calendar_one slot1", 32'h2, rd);
        bus(1'b0, scc_pkg::OFS_CALENDAR_ONE_CFG, 32'h0);
        chk("calendar_one cfg", 32'h0002_0003, rd);
        bus(1'b0, scc_pkg::OFS_CALENDAR_ZERO_CFG, 32'h0);
        chk("calendar_zero cfg", 32'h0001_0005, rd);
        $display("test program done");
    endtask : t_program
    task automatic t_streams();
        bus(1'b1, scc_pkg::OFS_CTRL, 32'h0);
        run_frame(1'b0, e0, 5);
        bus(1'b1, scc_pkg::OFS_CTRL, 32'h2);
        run_frame(1'b1, e1, 6);
        $display("test streams done");
    endtask : t_streams
    task automatic t_link();
        int k;
        k = 0;
        chk("tx cal before", 32'h0, 32'(tx_cal));
        i_link_cal_sel <= 1'b1;
        while (!(tx_start === 1'b1 && tx_cal === 1'b1) && k < 200) begin
            @(posedge i_clk);
            k++;
        end
        chk("tx start", 32'h1, 32'(tx_start));
        for (int i = 0; i < 6; i++) begin
            chk("tx valid", 32'h1, 32'(tx_valid));
            chk("tx port", 32'(e1[i]), 32'(tx_port));
            chk("tx cal", 32'h1, 32'(tx_cal));
            chk("rx cal", 32'h1, 32'(o_stat_cal));
            @(posedge i_clk);
        end
        $display("test link done");
    endtask : t_link
    task automatic t_disable();
        bus(1'b1, scc_pkg::OFS_CTRL, 32'h1);
        @(posedge i_clk);
        repeat (3) begin
            chk("stopped", 32'h0, 32'(o_stat_valid));
            @(posedge i_clk);
        end
        bus(1'b0, scc_pkg::OFS_STATUS, 32'h0);
        chk("running", 32'h0, {31'h0, rd[0]});
        $display("test disable done");
    endtask : t_disable
    initial begin
        i_clk = 1'b0;
        i_arst_n = 1'b0;
        i_address = 5'h00;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        i_byteenable = 4'hF;
        i_link_cal_sel = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_program();
        t_streams();
        t_link();
        t_disable();
        end_of_test();
    end
    initial begin
        #250000;
        bad_count++;
        end_of_test();
    end
endmodule : scc_calendar_cfg_tb
